/* File: sonar_ranging_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - a high range trigger starts a new measurement cycle.
// - each trigger rise yields exactly one burst of 16 pulses on burst_drive_out.
// - resonator_clock_out toggles only while the trigger is high.
// - the clock runs at resonator/8.5 for the first 16 cycles, then resonator/4.5.
// - echo_receive_in is ignored for a 3.8 ms blanking time after the trigger rises.
// - blank_bypass high ends blanking at once and enables the echo input.
// - force_blank high ignores the echo input and clears target_detect_out.
// - a 4-bit gain code steps through 12 values each cycle.
// - the gain code is the unsigned step number, 0 through 11, bit 3 the msb.
// - steps 0 to 10 end at fixed times after the trigger rise; step 11 holds to the fall.
// - clock and burst run at 49.4 kHz during the burst, then clock 93.3 kHz, burst off.
module sonar_ranging_sequencer
    import sonar_pkg::*;
#(
    parameter logic [TIMER_W-1:0] BLANK_CYC    = TIMER_W'(BLANK_CYC_DEF),
    parameter step_cyc_t          STEP_END_CYC = step_cyc_default()
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // host control pins
    input  wire logic range_trigger,
    input  wire logic blank_bypass,
    input  wire logic force_blank,
    // analogue receiver
    input  wire logic echo_receive_in,
    output logic      target_detect_out,
    output logic      gain_bit0,
    output logic      gain_bit1,
    output logic      gain_bit2,
    output logic      gain_bit3,
    // transducer side
    output logic      resonator_clock_out,
    output logic      burst_drive_out
);

    // ============================================================
    // state
    typedef struct packed {
        logic [IN_N-1:0]    s1;
        logic [IN_N-1:0]    s2;
        logic [IN_N-1:0]    s3;
        logic [IN_N-1:0]    filt;
        seq_state_t         st;
        logic [TIMER_W-1:0] timer;
        logic [PULSE_W-1:0] pulses;
        logic [GAIN_W-1:0]  gain;
        logic               bypassed;
        logic               osc;
        logic               burst;
        logic               detect;
    } seq_t;

    seq_t                r_ff;
    seq_t                nxt_r;
    logic                tick;
    logic                trig_f;
    logic                bypass_f;
    logic                fblank_f;
    logic                echo_f;
    logic                blank_now;
    logic [HALF_W-1:0]   half_cyc;

    assign trig_f    = r_ff.filt[IN_TRIG];
    assign bypass_f  = r_ff.filt[IN_BYPASS];
    assign fblank_f  = r_ff.filt[IN_FBLANK];
    assign echo_f    = r_ff.filt[IN_ECHO];
    // bypass acts in the same cycle it is seen, and stays latched
    assign blank_now = !r_ff.bypassed && !bypass_f && (r_ff.timer < BLANK_CYC);
    assign half_cyc  = (r_ff.st == ST_TX) ? HALF_TX_CYC : HALF_RX_CYC;

    // ============================================================
    // resonator clock divider
    half_period_timer u_timer (
        .clk      (clk),
        .rstn     (rstn),
        .run      (r_ff.st != ST_IDLE),
        .half_cyc (half_cyc),
        .tick     (tick)
    );

    // ============================================================
    // next state
    always_comb
    begin
        nxt_r    = r_ff;
        // a change counts only once stages two and three agree
        nxt_r.s1[IN_TRIG]   = range_trigger;
        nxt_r.s1[IN_BYPASS] = blank_bypass;
        nxt_r.s1[IN_FBLANK] = force_blank;
        nxt_r.s1[IN_ECHO]   = echo_receive_in;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.filt = (r_ff.s2 & r_ff.s3) | (r_ff.filt & (r_ff.s2 ^ r_ff.s3));

        case (r_ff.st)
            ST_IDLE:
            begin
                if (trig_f)
                begin
                    nxt_r.st       = ST_TX;
                    nxt_r.timer    = '0;
                    nxt_r.pulses   = '0;
                    nxt_r.gain     = '0;
                    nxt_r.bypassed = 1'b0;
                    nxt_r.detect   = 1'b0;
                end
            end
            ST_TX:
            begin
                if (tick)
                begin
                    nxt_r.osc   = ~r_ff.osc;
                    nxt_r.burst = ~r_ff.osc;
                    if (r_ff.osc)
                    begin
                        nxt_r.pulses = r_ff.pulses + PULSE_W'(1);
                        if (r_ff.pulses == LAST_PULSE)
                        begin
                            // sixteenth pulse done: burst off, faster clock
                            nxt_r.st    = ST_LISTEN;
                            nxt_r.burst = 1'b0;
                        end
                    end
                end
            end
            ST_LISTEN:
            begin
                if (tick)
                    nxt_r.osc = ~r_ff.osc;
            end
            default:
            begin
                nxt_r.st = ST_IDLE;
            end
        endcase

        if (r_ff.st != ST_IDLE)
        begin
            if (r_ff.timer != {TIMER_W{1'b1}})
                nxt_r.timer = r_ff.timer + TIMER_W'(1);
            // last step has no end time; it waits for the trigger to fall
            if (r_ff.gain != GAIN_LAST && r_ff.timer == STEP_END_CYC[r_ff.gain])
                nxt_r.gain = r_ff.gain + GAIN_W'(1);
            if (bypass_f)
                nxt_r.bypassed = 1'b1;
            if (fblank_f)
                nxt_r.detect = 1'b0;
            else if (echo_f && !blank_now)
                nxt_r.detect = 1'b1;
        end

        if (!trig_f)
        begin
            nxt_r.st       = ST_IDLE;
            nxt_r.osc      = 1'b0;
            nxt_r.burst    = 1'b0;
            nxt_r.detect   = 1'b0;
            nxt_r.gain     = '0;
            nxt_r.timer    = '0;
            nxt_r.pulses   = '0;
            nxt_r.bypassed = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    // ============================================================
    // outputs, each a flip-flop bit
    assign target_detect_out   = r_ff.detect;
    assign gain_bit0           = r_ff.gain[0];
    assign gain_bit1           = r_ff.gain[1];
    assign gain_bit2           = r_ff.gain[2];
    assign gain_bit3           = r_ff.gain[3];
    assign resonator_clock_out = r_ff.osc;
    assign burst_drive_out     = r_ff.burst;

    // ============================================================
    // checks
    int unsigned burst_rises_ff;
    int unsigned half_len_ff;

    always_ff @(posedge clk)
    begin
        // idle restarts both, so the first half period is measured from cycle start
        if (!rstn || r_ff.st == ST_IDLE)
        begin
            burst_rises_ff <= 0;
            half_len_ff    <= 0;
        end
        else
        begin
            if (!r_ff.burst && nxt_r.burst)
                burst_rises_ff <= burst_rises_ff + 1;
            if (r_ff.osc != nxt_r.osc)
                half_len_ff <= 1;
            else
                half_len_ff <= half_len_ff + 1;
        end
    end

    a_trigger_starts: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st == ST_IDLE && trig_f) |=> (r_ff.st == ST_TX && r_ff.timer == '0))
        else $error("trigger did not start a cycle");

    a_sixteen_pulses: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st == ST_TX && nxt_r.st == ST_LISTEN) |-> (burst_rises_ff == 16))
        else $error("burst did not hold sixteen pulses");

    a_osc_idle_low: assert property (
        @(posedge clk) disable iff (!rstn)
        !trig_f |=> (!resonator_clock_out && !burst_drive_out))
        else $error("clock or burst active with trigger low");

    a_tx_half_period: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st == ST_TX && $past(r_ff.st) == ST_TX && $changed(resonator_clock_out)
         && $past(half_len_ff) > 1) |-> ($past(half_len_ff) == int'(HALF_TX_CYC)))
        else $error("transmit half period wrong");

    a_listen_quiet: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st == ST_LISTEN) |-> !burst_drive_out)
        else $error("burst active after transmit");

    a_blank_masks: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(target_detect_out) |-> $past(!blank_now && echo_f && !fblank_f))
        else $error("detect set during blanking");

    a_force_clears: assert property (
        @(posedge clk) disable iff (!rstn)
        fblank_f |=> !target_detect_out)
        else $error("force blank did not clear detect");

    a_bypass_opens: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st != ST_IDLE && trig_f && bypass_f && echo_f && !fblank_f)
            |=> target_detect_out)
        else $error("bypass did not enable echo input");

    a_gain_range: assert property (
        @(posedge clk) disable iff (!rstn)
        r_ff.gain <= GAIN_LAST)
        else $error("gain code past last step");

    a_gain_steps: assert property (
        @(posedge clk) disable iff (!rstn)
        ($changed(r_ff.gain) && r_ff.st != ST_IDLE && $past(r_ff.st) != ST_IDLE)
            |-> (r_ff.gain == $past(r_ff.gain) + GAIN_W'(1)))
        else $error("gain code skipped a step");

    a_gain_timing: assert property (
        @(posedge clk) disable iff (!rstn)
        (r_ff.st != ST_IDLE && trig_f && r_ff.gain != GAIN_LAST
         && r_ff.timer == STEP_END_CYC[r_ff.gain])
            |=> (r_ff.gain == $past(r_ff.gain) + GAIN_W'(1)))
        else $error("gain step ended at wrong time");

    a_detect_held: assert property (
        @(posedge clk) disable iff (!rstn)
        (target_detect_out && trig_f && !fblank_f) |=> target_detect_out)
        else $error("detect dropped without cause");

    a_trigger_low_idle: assert property (
        @(posedge clk) disable iff (!rstn)
        !trig_f |=> (r_ff.st == ST_IDLE && r_ff.gain == '0 && !target_detect_out))
        else $error("trigger low did not idle");

endmodule

/* File: sonar_pkg.sv */
// ============================================================
// sonar ranging sequencer constants
package sonar_pkg;

    // ============================================================
    // clock and time base
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
    localparam int unsigned TIMER_W      = 20;

    // ============================================================
    // oscillator rates (420 kHz resonator / 8.5 and / 4.5)
    localparam int unsigned TX_FREQ_HZ   = 49_400;
    localparam int unsigned RX_FREQ_HZ   = 93_300;
    localparam int unsigned HALF_W       = 9;
    localparam logic [HALF_W-1:0] HALF_TX_CYC = HALF_W'(CLK_HZ / (2 * TX_FREQ_HZ));
    localparam logic [HALF_W-1:0] HALF_RX_CYC = HALF_W'(CLK_HZ / (2 * RX_FREQ_HZ));

    // ============================================================
    // burst, blanking, gain
    localparam int unsigned PULSE_W      = 5;
    localparam logic [PULSE_W-1:0] LAST_PULSE = 5'h0F;
    localparam int unsigned BLANK_US     = 3800;
    localparam int unsigned BLANK_CYC_DEF = BLANK_US * CYC_PER_US;
    localparam int unsigned GAIN_W       = 4;
    localparam logic [GAIN_W-1:0] GAIN_LAST = 4'hB;
    localparam int unsigned TIMED_STEPS  = 11;
    localparam int unsigned STEP_END_US [0:TIMED_STEPS-1] =
        '{2380, 5120, 7870, 10610, 13350, 16090, 18840, 21580, 27070, 32550, 38040};

    typedef logic [TIMER_W-1:0] step_cyc_t [0:TIMED_STEPS-1];

    function automatic step_cyc_t step_cyc_default();
        step_cyc_t r;
        for (int i = 0; i < TIMED_STEPS; i++)
        begin
            r[i] = TIMER_W'(STEP_END_US[i] * CYC_PER_US);
        end
        return r;
    endfunction

    // ============================================================
    // pin input positions in the synchroniser vector
    localparam int unsigned IN_N       = 4;
    localparam int unsigned IN_TRIG    = 0;
    localparam int unsigned IN_BYPASS  = 1;
    localparam int unsigned IN_FBLANK  = 2;
    localparam int unsigned IN_ECHO    = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_LISTEN} seq_state_t;

endpackage

/* File: half_period_timer.sv */
`timescale 1ns/1ps
// ============================================================
// half-period tick source for the resonator clock
module half_period_timer
    import sonar_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // control
    input  wire logic              run,
    input  wire logic [HALF_W-1:0] half_cyc,
    // tick, one cycle per half period
    output logic                   tick
);

    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic              tick;
    } tmr_t;

    tmr_t r_ff;
    tmr_t nxt_r;

    always_comb
    begin
        nxt_r      = r_ff;
        nxt_r.tick = 1'b0;
        if (!run)
        begin
            nxt_r.cnt = '0;
        end
        else if (r_ff.cnt >= half_cyc - HALF_W'(1))
        begin
            // >= so a shorter period taking over never overruns
            nxt_r.cnt  = '0;
            nxt_r.tick = 1'b1;
        end
        else
        begin
            nxt_r.cnt = r_ff.cnt + HALF_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign tick = r_ff.tick;

endmodule

/* File: sonar_echo_model.sv */
`timescale 1ns/1ps
// ============================================================
// receiver model: echo pulses at set delays after a trigger rise
module sonar_echo_model
(
    // clock
    input  wire logic clk,
    // host side
    input  wire logic range_trigger,
    input  wire integer echo_a,
    input  wire integer echo_b,
    // receiver output
    output logic      echo_receive_in
);
    int   t      = 0;
    logic trig_d = 1'b0;

    initial echo_receive_in = 1'b0;

    // 8-cycle pulses so the input synchroniser surely sees them
    always @(posedge clk)
    begin
        trig_d          <= range_trigger;
        t               <= (range_trigger && !trig_d) ? 0 : t + 1;
        echo_receive_in <= range_trigger && ((t >= echo_a && t < echo_a + 8) ||
                                             (t >= echo_b && t < echo_b + 8));
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sonar_pkg::*;

    // ============================================================
    // shortened counts; steps end after the burst so both are seen
    function automatic step_cyc_t mk_ends();
        step_cyc_t r;
        for (int i = 0; i < TIMED_STEPS; i++)
        begin
            r[i] = TIMER_W'(9000 + 500 * i);
        end
        return r;
    endfunction
    localparam logic [TIMER_W-1:0] BLANK = 20'h000C8;
    localparam step_cyc_t          ENDS  = mk_ends();
    localparam int                 PWRUP = 1000;

    logic       clk, rstn, range_trigger, blank_bypass, force_blank, echo_receive_in;
    logic       target_detect_out, gain_bit0, gain_bit1, gain_bit2, gain_bit3;
    logic       resonator_clock_out, burst_drive_out, osc_d, burst_d;
    logic [3:0] gain;
    int         echo_a, echo_b, t0, miscompares, n_tests, pulses;
    int         cyc = 0;
    int         tog[$];

    assign gain = {gain_bit3, gain_bit2, gain_bit1, gain_bit0};

    sonar_ranging_sequencer #(.BLANK_CYC(BLANK), .STEP_END_CYC(ENDS)) i_sonar_ranging_sequencer
    (
        .clk(clk), .rstn(rstn), .range_trigger(range_trigger), .blank_bypass(blank_bypass),
        .force_blank(force_blank), .echo_receive_in(echo_receive_in),
        .target_detect_out(target_detect_out), .gain_bit0(gain_bit0), .gain_bit1(gain_bit1),
        .gain_bit2(gain_bit2), .gain_bit3(gain_bit3),
        .resonator_clock_out(resonator_clock_out), .burst_drive_out(burst_drive_out)
    );

    sonar_echo_model i_sonar_echo_model
    (
        .clk(clk), .range_trigger(range_trigger), .echo_a(echo_a), .echo_b(echo_b),
        .echo_receive_in(echo_receive_in)
    );

    always #20 clk = ~clk;

    // ============================================================
    // monitor: oscillator toggle times and burst pulse count
    always @(posedge clk)
    begin
        cyc     <= cyc + 1;
        osc_d   <= resonator_clock_out;
        burst_d <= burst_drive_out;
        if (resonator_clock_out !== osc_d)
            tog.push_back(cyc);
        if (burst_drive_out === 1'b1 && burst_d === 1'b0)
            pulses <= pulses + 1;
    end

    // ============================================================
    // compare tasks and reference model
    task automatic chk1(string nm, logic e, logic g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic chk4(string nm, logic [3:0] e, logic [3:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chkn(string nm, int e, int g);
        n_tests++;
        if (g != e)
        begin
            miscompares++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask

    function automatic logic [3:0] exp_gain(int t);
        int n;
        n = 0;
        for (int k = 0; k < TIMED_STEPS; k++)
        begin
            if (int'(ENDS[k]) + 6 < t)
                n++;
        end
        return 4'(n);
    endfunction

    task automatic at(int t);
        while (cyc - t0 < t)
            @(posedge clk);
    endtask

    task automatic start(logic byp);
        @(posedge clk);
        range_trigger <= 1'b1;
        blank_bypass  <= byp;
        t0 = cyc;
        tog.delete();
        pulses = 0;
    endtask

    task automatic burst_chk();
        int bad;
        bad = 0;
        for (int i = 1; i < tog.size(); i++)
        begin
            if (tog[i] - tog[i-1] != ((i <= 31) ? int'(HALF_TX_CYC) : int'(HALF_RX_CYC)))
                bad++;
        end
        chkn("burst pulses", 16, pulses);
        chkn("osc bad half periods", 0, bad);
        chkn("osc runs after burst", 1, int'(tog.size() > 40));
    endtask

    task automatic stop_chk();
        range_trigger <= 1'b0;
        blank_bypass  <= 1'b0;
        repeat (8) @(posedge clk);
        chk1("detect idle", 1'b0, target_detect_out);
        chk4("gain idle", 4'h0, gain);
        chk1("burst idle", 1'b0, burst_drive_out);
        tog.delete();
        repeat (300) @(posedge clk);
        chkn("osc toggles idle", 0, tog.size());
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ============================================================
    // watchdog: the run needs about 26000 cycles
    initial
    begin
        #2400000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        {range_trigger, blank_bypass, force_blank} = 3'h0;
        echo_a = 1000000;
        echo_b = 1000000;
        void'($urandom(32'h820744B4));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (PWRUP) @(posedge clk);
        chk1("osc before trigger", 1'b0, resonator_clock_out);
        // cycle A: echo inside blanking, echo after it, forced clear, gain sweep
        echo_a = 50 + $urandom % 100;
        echo_b = 400 + $urandom % 400;
        start(1'b0);
        at(300);
        chk1("detect blanked", 1'b0, target_detect_out);
        at(echo_b + 25);
        chk1("detect echo", 1'b1, target_detect_out);
        at(1000);
        force_blank <= 1'b1;
        at(1010);
        chk1("detect forced", 1'b0, target_detect_out);
        force_blank <= 1'b0;
        at(1100);
        chk1("detect stays clear", 1'b0, target_detect_out);
        for (int k = 0; k < TIMED_STEPS; k++)
        begin
            at(int'(ENDS[k]) - 20);
            chk4("gain in step", exp_gain(cyc - t0), gain);
            at(int'(ENDS[k]) + 20);
            chk4("gain after step", exp_gain(cyc - t0), gain);
        end
        at(int'(ENDS[10]) + 1000);
        chk4("gain last step", 4'hB, gain);
        burst_chk();
        stop_chk();
        $display("test A done");
        // cycle B: bypass, echo ignored under force blank
        echo_a = 30 + $urandom % 50;
        echo_b = 600;
        start(1'b1);
        at(echo_a + 25);
        chk1("detect bypass", 1'b1, target_detect_out);
        at(500);
        force_blank <= 1'b1;
        at(720);
        chk1("detect masked", 1'b0, target_detect_out);
        force_blank <= 1'b0;
        at(2000);
        chk4("gain early", exp_gain(cyc - t0), gain);
        at(9500);
        burst_chk();
        stop_chk();
        $display("test B done");
        wrap_up();
    end
endmodule
